// >>> hdl/pin_select_pkg.sv
// constants for the remappable pin select and change notify block
// assumes one core clock and synchronous active-high reset
package pin_select_pkg;
  localparam int SEL_W = 5;
  localparam int NUM_RP = 26;
  localparam int NUM_CN = 21;
  localparam int NUM_IN = 22;
  localparam int NUM_OUT_SRC = 22;
  localparam logic [SEL_W-1:0] IN_SEL_RESET = 5'h1F;
  localparam logic [SEL_W-1:0] OUT_SEL_RESET = 5'h00;
  // peripheral input index order
  localparam int IN_EXT_IRQ1 = 0;
  localparam int IN_EXT_IRQ2 = 1;
  localparam int IN_T2CK = 2;
  localparam int IN_T3CK = 3;
  localparam int IN_T4CK = 4;
  localparam int IN_T5CK = 5;
  localparam int IN_CAP1 = 6;
  localparam int IN_CAP2 = 7;
  localparam int IN_CAP7 = 8;
  localparam int IN_CAP8 = 9;
  localparam int IN_FAULT_A = 10;
  localparam int IN_U1RX = 11;
  localparam int IN_U1CTS = 12;
  localparam int IN_U2RX = 13;
  localparam int IN_U2CTS = 14;
  localparam int IN_S1DI = 15;
  localparam int IN_S1CK = 16;
  localparam int IN_S1SS = 17;
  localparam int IN_S2DI = 18;
  localparam int IN_S2CK = 19;
  localparam int IN_S2SS = 20;
  localparam int IN_CANRX = 21;
  // output select codes
  localparam logic [SEL_W-1:0] OUT_NULL = 5'h00;
  localparam logic [SEL_W-1:0] OUT_CMP1 = 5'h01;
  localparam logic [SEL_W-1:0] OUT_CMP2 = 5'h02;
  localparam logic [SEL_W-1:0] OUT_UART1_TX = 5'h03;
  localparam logic [SEL_W-1:0] OUT_UART1_RTS = 5'h04;
  localparam logic [SEL_W-1:0] OUT_U2TX = 5'h05;
  localparam logic [SEL_W-1:0] OUT_U2RTS = 5'h06;
  localparam logic [SEL_W-1:0] OUT_S1DO = 5'h07;
  localparam logic [SEL_W-1:0] OUT_S1CK = 5'h08;
  localparam logic [SEL_W-1:0] OUT_S1SS = 5'h09;
  localparam logic [SEL_W-1:0] OUT_S2DO = 5'h0A;
  localparam logic [SEL_W-1:0] OUT_S2CK = 5'h0B;
  localparam logic [SEL_W-1:0] OUT_S2SS = 5'h0C;
  localparam logic [SEL_W-1:0] OUT_CANTX = 5'h10;
  localparam logic [SEL_W-1:0] OUT_OCMP1 = 5'h12;
  localparam logic [SEL_W-1:0] OUT_OCMP2 = 5'h13;
  localparam logic [SEL_W-1:0] OUT_OCMP3 = 5'h14;
  localparam logic [SEL_W-1:0] OUT_OCMP4 = 5'h15;
  // unlock sequence keys on the oscillator control low byte
  localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
  typedef enum logic [1:0] {
    UL_IDLE = 2'b00,
    UL_KEY1 = 2'b01,
    UL_OPEN = 2'b10
  } unlock_state_e;
endpackage : pin_select_pkg

// >>> hdl/pin_out_select.sv
// one remappable pin's output multiplexer
// assumes peripheral outputs and enables are synchronous to clk
`timescale 1ns/1ps
module pin_out_select
  import pin_select_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [SEL_W-1:0] sel,
  input wire logic [NUM_OUT_SRC-1:0] periph_out,
  input wire logic [NUM_OUT_SRC-1:0] periph_drive,
  input wire logic port_latch,
  input wire logic port_dir_in,
  output logic pin_o,
  output logic pin_oe_n,
  output logic periph_owns
);
  logic next_pin_o;
  logic next_pin_oe_n;
  logic next_owns;
  logic [4:0] src;
  logic hit;

  // code to source index; unlisted codes fall back to the port
  always_comb begin
    hit = 1'b1;
    src = 5'h00;
    case (sel)
      OUT_CMP1: src = 5'h00;
      OUT_CMP2: src = 5'h01;
      OUT_UART1_TX: src = 5'h02;
      OUT_UART1_RTS: src = 5'h03;
      OUT_U2TX: src = 5'h04;
      OUT_U2RTS: src = 5'h05;
      OUT_S1DO: src = 5'h06;
      OUT_S1CK: src = 5'h07;
      OUT_S1SS: src = 5'h08;
      OUT_S2DO: src = 5'h09;
      OUT_S2CK: src = 5'h0A;
      OUT_S2SS: src = 5'h0B;
      OUT_CANTX: src = 5'h0C;
      OUT_OCMP1: src = 5'h0D;
      OUT_OCMP2: src = 5'h0E;
      OUT_OCMP3: src = 5'h0F;
      OUT_OCMP4: src = 5'h10;
      default: hit = 1'b0;
    endcase
  end

  // peripheral wins only while it actively drives
  always_comb begin
    next_owns = hit && periph_drive[src];
    next_pin_o = next_owns ? periph_out[src] : port_latch;
    next_pin_oe_n = next_owns ? 1'b0 : port_dir_in;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_o <= 1'b0;
      pin_oe_n <= 1'b1;
      periph_owns <= 1'b0;
    end else begin
      pin_o <= next_pin_o;
      pin_oe_n <= next_pin_oe_n;
      periph_owns <= next_owns;
    end
  end
endmodule : pin_out_select

// >>> hdl/io_pin_select_and_change_notify.sv
// remappable pin select network and input change notification
// assumes pins are already synchronous to clk and software writes come as strobes
`timescale 1ns/1ps
module io_pin_select_and_change_notify
  import pin_select_pkg::*;
#(
  parameter int PINS = NUM_RP,
  parameter int CN_PINS = NUM_CN
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sleep_mode,
  input wire logic [PINS-1:0] remappable_pin_in,
  output logic [PINS-1:0] remappable_pin_out,
  output logic [PINS-1:0] remappable_pin_oe_n,
  output logic [PINS-1:0] periph_owns_pin,
  input wire logic [PINS-1:0] port_latch,
  input wire logic [PINS-1:0] pin_direction_bits,
  input wire logic [NUM_OUT_SRC-1:0] periph_out,
  input wire logic [NUM_OUT_SRC-1:0] periph_drive,
  output logic [NUM_IN-1:0] periph_in,
  input wire logic in_sel_we,
  input wire logic [4:0] in_sel_index,
  input wire logic [SEL_W-1:0] in_sel_wdata,
  input wire logic out_sel_we,
  input wire logic [4:0] out_sel_index,
  input wire logic [SEL_W-1:0] out_sel_wdata,
  input wire logic osc_ctrl_low_we,
  input wire logic [7:0] osc_ctrl_low_wdata,
  input wire logic lock_we,
  input wire logic lock_wdata,
  output logic map_write_lock,
  input wire logic [15:0] change_irq_enable_low,
  input wire logic [15:0] change_irq_enable_high,
  input wire logic [15:0] pullup_enable_low,
  input wire logic [15:0] pullup_enable_high,
  input wire logic [CN_PINS-1:0] change_notify_pin,
  output logic [CN_PINS-1:0] pullup_on,
  input wire logic change_irq_clear,
  output logic change_irq
);
  logic [SEL_W-1:0] input_select_regs [NUM_IN];
  logic [SEL_W-1:0] next_input_select_regs [NUM_IN];
  logic [SEL_W-1:0] output_select_regs [PINS];
  logic [SEL_W-1:0] next_output_select_regs [PINS];
  unlock_state_e ul_state;
  unlock_state_e next_ul_state;
  logic next_lock;
  logic [CN_PINS-1:0] cn_prev;
  logic [CN_PINS-1:0] next_cn_prev;
  logic [CN_PINS-1:0] cn_en;
  logic [CN_PINS-1:0] cn_diff;
  logic next_change_irq;
  logic [NUM_IN-1:0] next_periph_in;

  assign cn_en = CN_PINS'({change_irq_enable_high, change_irq_enable_low});
  assign pullup_on = CN_PINS'({pullup_enable_high, pullup_enable_low});

  always_comb begin
    next_ul_state = ul_state;
    next_lock = map_write_lock;
    case (ul_state)
      UL_IDLE: begin
        if (osc_ctrl_low_we && osc_ctrl_low_wdata == UNLOCK_KEY1) begin
          next_ul_state = UL_KEY1;
        end
      end
      UL_KEY1: begin
        if (osc_ctrl_low_we && osc_ctrl_low_wdata == UNLOCK_KEY2) begin
          next_ul_state = UL_OPEN;
        end else if (osc_ctrl_low_we || lock_we) begin
          next_ul_state = UL_IDLE;
        end
      end
      UL_OPEN: begin
        // one lock change per unlock, an oscillator control write closes the window
        if (lock_we) begin
          next_lock = lock_wdata;
          next_ul_state = UL_IDLE;
        end else if (osc_ctrl_low_we) begin
          next_ul_state = UL_IDLE;
        end
      end
      default: next_ul_state = UL_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ul_state <= UL_IDLE;
      map_write_lock <= 1'b0;
    end else begin
      ul_state <= next_ul_state;
      map_write_lock <= next_lock;
    end
  end

  // selection writes gated by the lock
  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      next_input_select_regs[i] = input_select_regs[i];
    end
    for (int j = 0; j < PINS; j++) begin
      next_output_select_regs[j] = output_select_regs[j];
    end
    if (in_sel_we && !map_write_lock && int'(in_sel_index) < NUM_IN) begin
      next_input_select_regs[in_sel_index] = in_sel_wdata;
    end
    if (out_sel_we && !map_write_lock && int'(out_sel_index) < PINS) begin
      next_output_select_regs[out_sel_index] = out_sel_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_IN; i++) begin
        input_select_regs[i] <= IN_SEL_RESET;
      end
      for (int j = 0; j < PINS; j++) begin
        output_select_regs[j] <= OUT_SEL_RESET;
      end
    end else begin
      input_select_regs <= next_input_select_regs;
      output_select_regs <= next_output_select_regs;
    end
  end

  // field value n picks pin n; out of range reads low
  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      if (int'(input_select_regs[i]) < PINS) begin
        next_periph_in[i] = remappable_pin_in[input_select_regs[i]];
      end else begin
        next_periph_in[i] = 1'b0;
      end
    end
  end

  // one registered input per listed peripheral
  always_ff @(posedge clk) begin
    if (rst) begin
      periph_in <= '0;
    end else begin
      periph_in <= next_periph_in;
    end
  end

  // one output mux per remappable pin
  generate
    for (genvar g = 0; g < PINS; g++) begin : g_pin
      // port driver off while peripheral drives
      pin_out_select u_sel (
        .clk(clk),
        .rst(rst),
        .sel(output_select_regs[g]),
        .periph_out(periph_out),
        .periph_drive(periph_drive),
        .port_latch(port_latch[g]),
        .port_dir_in(pin_direction_bits[g]),
        .pin_o(remappable_pin_out[g]),
        .pin_oe_n(remappable_pin_oe_n[g]),
        .periph_owns(periph_owns_pin[g])
      );
    end
  endgenerate

  // sleep only gates core clock upstream; this path stays on clk, which keeps running
  always_comb begin
    cn_diff = (change_notify_pin ^ cn_prev) & cn_en;
    next_cn_prev = change_notify_pin;
    // sticky request, set wins over clear
    next_change_irq = (|cn_diff) || (change_irq && !change_irq_clear);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cn_prev <= '0;
      change_irq <= 1'b0;
    end else begin
      cn_prev <= next_cn_prev;
      change_irq <= next_change_irq;
    end
  end

  property p_irq_on_change;
    @(posedge clk) disable iff (rst)
    (|((change_notify_pin ^ cn_prev) & cn_en)) |=> change_irq;
  endproperty
  a_irq_on_change: assert property (p_irq_on_change) else $error("change not flagged");

  property p_irq_sleep;
    @(posedge clk) disable iff (rst)
    (sleep_mode && |((change_notify_pin ^ cn_prev) & cn_en)) |=> change_irq;
  endproperty
  a_irq_sleep: assert property (p_irq_sleep) else $error("change lost in sleep");

  property p_no_spurious;
    @(posedge clk) disable iff (rst)
    (!change_irq && !(|((change_notify_pin ^ cn_prev) & cn_en))) |=> !change_irq;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("spurious change flag");

  property p_locked_in;
    @(posedge clk) disable iff (rst)
    (map_write_lock && in_sel_we && int'(in_sel_index) < NUM_IN) |=>
      input_select_regs[$past(in_sel_index)] == $past(input_select_regs[in_sel_index]);
  endproperty
  a_locked_in: assert property (p_locked_in) else $error("locked input map changed");

  property p_unlock_seq;
    @(posedge clk) disable iff (rst)
    $changed(map_write_lock) |-> $past(ul_state) == UL_OPEN;
  endproperty
  a_unlock_seq: assert property (p_unlock_seq) else $error("lock changed without keys");

  property p_in_route;
    @(posedge clk) disable iff (rst)
    (int'(input_select_regs[IN_U1RX]) < PINS) |=>
      periph_in[IN_U1RX] == $past(remappable_pin_in[input_select_regs[IN_U1RX]]);
  endproperty
  a_in_route: assert property (p_in_route) else $error("input route wrong");

  property p_in_tied;
    @(posedge clk) disable iff (rst)
    (int'(input_select_regs[IN_EXT_IRQ1]) >= PINS) |=> !periph_in[IN_EXT_IRQ1];
  endproperty
  a_in_tied: assert property (p_in_tied) else $error("out of range input not low");

  property p_null_port;
    @(posedge clk) disable iff (rst)
    (output_select_regs[0] == OUT_NULL) |=> !periph_owns_pin[0] && remappable_pin_out[0] == $past(port_latch[0]);
  endproperty
  a_null_port: assert property (p_null_port) else $error("null code not port");

  property p_cantx;
    @(posedge clk) disable iff (rst)
    (output_select_regs[1] == OUT_CANTX && periph_drive[12]) |=>
      !remappable_pin_oe_n[1] && remappable_pin_out[1] == $past(periph_out[12]);
  endproperty
  a_cantx: assert property (p_cantx) else $error("can transmit not routed");

  property p_unlisted;
    @(posedge clk) disable iff (rst)
    (output_select_regs[2] == 5'h0D) |=> !periph_owns_pin[2];
  endproperty
  a_unlisted: assert property (p_unlisted) else $error("unlisted code took pin");

  property p_locked_out;
    @(posedge clk) disable iff (rst)
    (map_write_lock && out_sel_we && int'(out_sel_index) < PINS) |=>
      output_select_regs[$past(out_sel_index)] == $past(output_select_regs[out_sel_index]);
  endproperty
  a_locked_out: assert property (p_locked_out) else $error("locked output map changed");

  property p_open_write;
    @(posedge clk) disable iff (rst)
    (!map_write_lock && in_sel_we && int'(in_sel_index) < NUM_IN) |=>
      input_select_regs[$past(in_sel_index)] == $past(in_sel_wdata);
  endproperty
  a_open_write: assert property (p_open_write) else $error("open input map write lost");

  property p_lock_taken;
    @(posedge clk) disable iff (rst)
    (lock_we && ul_state == UL_OPEN) |=> map_write_lock == $past(lock_wdata);
  endproperty
  a_lock_taken: assert property (p_lock_taken) else $error("unlocked lock write lost");

  property p_irq_clear;
    @(posedge clk) disable iff (rst)
    (change_irq && change_irq_clear && !(|((change_notify_pin ^ cn_prev) & cn_en))) |=> !change_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("change flag not cleared");

  property p_port_dir;
    @(posedge clk) disable iff (rst)
    (output_select_regs[3] == OUT_NULL) |=> remappable_pin_oe_n[3] == $past(pin_direction_bits[3]);
  endproperty
  a_port_dir: assert property (p_port_dir) else $error("null code lost port direction");

  c_unlock: cover property (@(posedge clk) disable iff (rst) ul_state == UL_OPEN ##1 !map_write_lock ##1 in_sel_we);
  c_irq: cover property (@(posedge clk) disable iff (rst) !change_irq ##1 change_irq);
  c_own: cover property (@(posedge clk) disable iff (rst) periph_owns_pin[0]);
  c_refused: cover property (@(posedge clk) disable iff (rst) map_write_lock && out_sel_we);
  c_cantx: cover property (@(posedge clk) disable iff (rst) periph_owns_pin[1] && output_select_regs[1] == OUT_CANTX);
endmodule : io_pin_select_and_change_notify

// >>> tb/pin_world.sv
// far-side model: the pins around the block and what drives them
// assumes the bench sets the far-side levels and float marks at the falling edge
`timescale 1ns/1ps
module pin_world
  import pin_select_pkg::*;
(
  input wire logic [NUM_RP-1:0] pin_out,
  input wire logic [NUM_RP-1:0] pin_oe_n,
  input wire logic [NUM_RP-1:0] ext_level,
  output logic [NUM_RP-1:0] pin_level,
  input wire logic [NUM_CN-1:0] cn_ext,
  input wire logic [NUM_CN-1:0] cn_float,
  input wire logic [NUM_CN-1:0] pullup_on,
  output logic [NUM_CN-1:0] cn_level
);
  // device wins the pin while its enable is low, else the far side drives
  always_comb begin
    for (int i = 0; i < NUM_RP; i++) begin
      pin_level[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
    end
  end
  // a released pin goes high on its pull-up, else drifts off its last level
  always_comb begin
    for (int i = 0; i < NUM_CN; i++) begin
      cn_level[i] = !cn_float[i] ? cn_ext[i] : (pullup_on[i] ? 1'h1 : ~cn_ext[i]);
    end
  end
endmodule : pin_world

// >>> tb/io_pin_select_and_change_notify_bench.sv
// self-checking bench for the pin select and change notify block
// assumes pin_world stands for the pins; peripherals are plain random levels
`timescale 1ns/1ps
module io_pin_select_and_change_notify_bench;
  import pin_select_pkg::*;
  logic clk = 1'h0, rst = 1'h1, slp = 1'h0;
  logic [25:0] p_lvl, p_out, p_oe_n, owns, latch = '0, dir = '1, ext = '0;
  logic [21:0] pout = '0, pdrv = '0, p_in;
  logic isw = 1'h0, osw = 1'h0, ow = 1'h0, lw = 1'h0, ld = 1'h0, clr = 1'h0, lock, irq;
  logic [4:0] isi = '0, isd = '0, osi = '0, osd = '0;
  logic [7:0] od = '0;
  logic [15:0] cel = '0, ceh = '0, pul = '0, puh = '0;
  logic [20:0] cn_ext = '0, cn_flt = '0, cn_lvl, pu_on;
  int n_mismatch = 0, compares = 0, n, p;

  always #4 clk = ~clk;

  io_pin_select_and_change_notify dut (
    .clk(clk), .rst(rst), .sleep_mode(slp), .remappable_pin_in(p_lvl), .remappable_pin_out(p_out),
    .remappable_pin_oe_n(p_oe_n), .periph_owns_pin(owns), .port_latch(latch), .pin_direction_bits(dir),
    .periph_out(pout), .periph_drive(pdrv), .periph_in(p_in), .in_sel_we(isw), .in_sel_index(isi),
    .in_sel_wdata(isd), .out_sel_we(osw), .out_sel_index(osi), .out_sel_wdata(osd),
    .osc_ctrl_low_we(ow), .osc_ctrl_low_wdata(od), .lock_we(lw), .lock_wdata(ld), .map_write_lock(lock),
    .change_irq_enable_low(cel), .change_irq_enable_high(ceh), .pullup_enable_low(pul),
    .pullup_enable_high(puh), .change_notify_pin(cn_lvl), .pullup_on(pu_on),
    .change_irq_clear(clr), .change_irq(irq));

  pin_world world (.pin_out(p_out), .pin_oe_n(p_oe_n), .ext_level(ext), .pin_level(p_lvl),
    .cn_ext(cn_ext), .cn_float(cn_flt), .pullup_on(pu_on), .cn_level(cn_lvl));

  // output code to peripheral index, -1 for unlisted codes
  function automatic int out_index(input logic [4:0] c);
    if (c >= 5'h01 && c <= 5'h0C) return int'(c) - 1;
    if (c == 5'h10) return 12;
    if (c >= 5'h12 && c <= 5'h15) return int'(c) - 5;
    return -1;
  endfunction : out_index

  // expected {owns, oe_n, level} of one pin
  function automatic logic [2:0] exp_out(input logic [4:0] c, input int pin);
    int k;
    k = out_index(c);
    if (k >= 0 && pdrv[k] === 1'h1) return {1'h1, 1'h0, pout[k]};
    return {1'h0, dir[pin], latch[pin]};
  endfunction : exp_out

  // selects past the pin count read as a tied-low input
  function automatic logic exp_in(input int sel, input logic [25:0] lv);
    if (sel < NUM_RP) return lv[sel];
    return 1'h0;
  endfunction : exp_in

  task automatic check(input logic [25:0] got, input logic [25:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic ticks(input int k);
    repeat (k) @(negedge clk);
  endtask : ticks

  task automatic sel_in(input int i, input int sel);
    @(negedge clk);
    isw = 1'h1;
    isi = 5'(i);
    isd = 5'(sel);
    @(negedge clk);
    isw = 1'h0;
  endtask : sel_in

  task automatic sel_out(input int pin, input logic [4:0] c);
    @(negedge clk);
    osw = 1'h1;
    osi = 5'(pin);
    osd = c;
    @(negedge clk);
    osw = 1'h0;
  endtask : sel_out

  task automatic osc(input logic [7:0] d);
    @(negedge clk);
    ow = 1'h1;
    od = d;
    @(negedge clk);
    ow = 1'h0;
  endtask : osc

  task automatic lock_wr(input logic d);
    @(negedge clk);
    lw = 1'h1;
    ld = d;
    @(negedge clk);
    lw = 1'h0;
  endtask : lock_wr

  task automatic pulse_clr;
    @(negedge clk);
    clr = 1'h1;
    @(negedge clk);
    clr = 1'h0;
  endtask : pulse_clr

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  initial begin
    void'($urandom(32'hBF4B6586));
    ticks(19);
    check(p_oe_n, '1, "oe_n in reset");
    check(p_out | owns, '0, "drive in reset");
    check(26'({lock, irq, p_in}), '0, "flags in reset");
    ticks(1);
    rst = 1'h0;
    $display("reset test done");
    // directions stay input while inputs are mapped
    for (int i = 0; i < NUM_IN; i++) begin
      n = (i == 0) ? 25 : (i == 1) ? 26 : int'($urandom_range(31, 0));
      sel_in(i, n);
      for (int v = 0; v < 2; v++) begin
        ext = v ? ~ext : 26'($urandom);
        ticks(2);
        check(26'(p_in[i]), 26'(exp_in(n, ext)), "input route");
      end
    end
    $display("input select test done");
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      pul = 16'($urandom);
      puh = 16'($urandom);
      cn_flt = '1;
      #1;
      check(26'(pu_on), 26'({puh[4:0], pul}), "pull-up");
    end
    @(negedge clk);
    cn_flt = '0;
    $display("pull-up test done");
    // the odd-numbered pins are run with sleep high
    for (int j = 0; j < NUM_CN; j++) begin
      @(negedge clk);
      {ceh, cel} = '0;
      slp = j[0];
      cn_ext = 21'($urandom);
      ticks(2);
      pulse_clr();
      ticks(1);
      {ceh, cel} = 32'h1 << j;
      ticks(2);
      cn_ext[(j + 1) % NUM_CN] = ~cn_ext[(j + 1) % NUM_CN];
      ticks(3);
      check(26'(irq), 26'h0, "masked pin");
      cn_ext[j] = ~cn_ext[j];
      ticks(3);
      check(26'(irq), 26'h1, "change request");
      pulse_clr();
      ticks(1);
      check(26'(irq), 26'h0, "request cleared");
    end
    slp = 1'h0;
    $display("change notify test done");
    pdrv = '1;
    pout = 22'($urandom);
    sel_in(IN_U1RX, 3);
    osc(8'h46);
    osc(8'h57);
    lock_wr(1'h1);
    ticks(1);
    check(26'(lock), 26'h1, "lock set");
    sel_in(IN_U1RX, 4);
    sel_out(5, OUT_UART1_TX);
    ext = 26'h0000008;
    ticks(3);
    check(26'(p_in[IN_U1RX]), 26'h1, "locked input select");
    check(26'(owns[5]), 26'h0, "locked output select");
    lock_wr(1'h0);
    osc(8'h46);
    osc(8'h12);
    osc(8'h57);
    lock_wr(1'h0);
    ticks(1);
    check(26'(lock), 26'h1, "lock without keys");
    osc(8'h46);
    osc(8'h57);
    lock_wr(1'h0);
    ticks(1);
    check(26'(lock), 26'h0, "lock cleared");
    $display("lock test done");
    {puh, pul} = '0;
    // every code twice; null, 13 and can on the watched pins
    for (int k = 0; k < 64; k++) begin
      p = (k % 32 == 0) ? 0 : (k % 32 == 13) ? 2 : (k % 32 == 16) ? 1 : int'($urandom_range(25, 0));
      pout = 22'($urandom);
      pdrv = 22'($urandom);
      pdrv[12] = k[5];
      latch = 26'($urandom);
      dir = 26'($urandom);
      sel_out(p, 5'(k));
      ticks(2);
      check(26'({owns[p], p_oe_n[p], p_out[p]}), 26'(exp_out(5'(k), p)), "pin output");
    end
    $display("output select test done");
    stop_test();
  end

  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end
endmodule : io_pin_select_and_change_notify_bench
